// [verilog/sector_write_pkg.sv]
// shared constants and carrier types for the sector write sequencer
// assumes a single pclk domain; drive pins enter through synchronisers
`default_nettype none
package sector_write_pkg;
	localparam logic [6:0] WORDS_PER_SECTOR = 7'h6C; // 108 words
	localparam logic [6:0] WC_SYNC          = 7'h5C; // 92
	localparam logic [6:0] WC_ADDR          = 7'h5B; // 91
	localparam logic [6:0] WC_LAST          = 7'h01;
	localparam logic [3:0] BR_LAST          = 4'hF;
	localparam logic [3:0] BR_SYNC_LOAD     = 4'h2;
	localparam logic [3:0] BR_SR1_LOAD      = 4'hC;
	localparam logic [3:0] BR_SR2_LOAD      = 4'h1;
	localparam logic [3:0] BR_CHECK_END     = 4'h7;
	localparam logic [3:0] BR_BUF_SHIFT     = 4'h2;
	localparam logic [3:0] BR_UPPER         = 4'h8;
	localparam logic [7:0] SYNC_PATTERN     = 8'h1E;
	localparam logic [13:0] FILE_ADDR_RESET = 14'h0000;
	localparam int         HEAD_BIT         = 5;
	// register byte offsets: control, file address, status
	localparam logic [11:0] A_CTRL          = 12'h000;
	localparam logic [11:0] A_FILE_ADDR     = 12'h004;
	localparam logic [11:0] A_STAT          = 12'h008;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_WRITE = 2'b10,
		ST_SLIP  = 2'b11
	} seq_state_t;

	// drive-side strobes after synchronisation
	typedef struct packed
	{
		logic write_clock_rise;
		logic sector_rise;
	} drive_events_t;
endpackage
`default_nettype wire

// [verilog/edge_sync.sv]
// two-flop synchroniser with rising-edge pulse for one drive pin
// assumes the pin is asynchronous to pclk
`default_nettype none
module edge_sync
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pin and result
	input  wire logic pin,
	output logic      rise
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// first stage only feeds the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign rise = sync_r & ~last_r;
endmodule
`default_nettype wire

// [verilog/disk_sector_write_sequencer.sv]
// write-sector sequencer: frames one sector onto the drive write data line
// assumes drive clock and sector pulse are async pins; APB on pclk
//
// How it works
// RQ1 - wait for first sector pulse, then drop read gate, raise write gate
// RQ2 - advance flag with first-sector clear increments file address
// RQ3 - word counter loads 108 at write start
// RQ4 - write start sets address phase and frame active flags
// RQ5 - equal selects without full indicator mean empty; with terminate, set drained
// RQ6 - bit ring 15 in frame with word count not one decrements count
// RQ7 - sync pattern loads check register at 92/ring 2, shifts out upper
// RQ8 - transfer strobe needs stage one, not two, idle exchange, channel
// RQ9 - sector flag gives transfer mode; strobe loads address shifters
// RQ10 - word count 92 clears sector flag
// RQ11 - check register drives write data at sync and check times
// RQ12 - data phase sets at word 91 ring 15
// RQ13 - shift bus drives write data in data phase or word 91
// RQ14 - data bits xor into check register low end
// RQ15 - upper-byte phase selects shifter two, else one, shifting per clock
// RQ16 - word 1 ring 15 clears data and address phase flags
// RQ17 - frame clears at ring 7 once address phase is clear
// RQ18 - word 91 clears first-sector flag
// RQ19 - word 1 idle frame sets advance flag, then one-clock increment flag
// RQ20 - sector, drained and idle frame set operation end
// RQ21 - ring 12 loads shifter one from latch high, ring 1 shifter two low
// RQ22 - data ring 2 with dump shifts buffer; latch captures at phase three
// RQ23 - word 1 idle sets cylinder match; head bit sets wrap memory
// RQ24 - wrap or empty-slip moves to slip state 3 and sets advance flag
// RQ25 - sector pulse after writing drops write gate and blank count
// RQ26 - drive pins synchronised; reset clears flags and counters, but sets read gate
`default_nettype none
module disk_sector_write_sequencer
(
	// system
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// drive link
	input  wire logic        write_clock_in,
	input  wire logic        sector_pulse_in,
	output logic             write_data_out,
	output logic             write_gate_flag,
	output logic             read_gate_flag,
	// buffer storage and exchange side
	input  wire logic [15:0] mos_buffer_output,
	input  wire logic        mos_clock_phase_three,
	input  wire logic        load_buffer_select,
	input  wire logic        dump_buffer_select,
	input  wire logic        buffer_full_indicator,
	input  wire logic        exchange_command_present,
	input  wire logic        channel_active_flag,
	output logic             buffer_shift_strobe,
	output logic             operation_end_flag
);
	sector_write_pkg::seq_state_t state_r;
	wire sector_write_pkg::drive_events_t ev;
	logic [13:0] file_address_counter;
	logic [6:0]  word_counter;
	logic [3:0]  bit_ring_counter;
	logic [7:0]  check_char_shift_reg;
	logic [7:0]  shift_register_one;
	logic [7:0]  shift_register_two;
	logic [15:0] output_latch;
	logic frame_active_flag, address_phase_flag, data_phase_flag;
	logic sector_flag, first_sector_flag, address_advance_flag;
	logic increment_pulse_flag, terminate_received, terminate_drained_flag;
	logic transfer_stage_one, transfer_stage_two, cylinder_match_flag;
	logic track_wrap_memory, blank_count_flag, written_r;
	logic frame_was_r;

	// drive pins cross into pclk domain
	edge_sync u_wclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (write_clock_in),
		.rise    (ev.write_clock_rise)
	); // RQ26
	edge_sync u_sec
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (sector_pulse_in),
		.rise    (ev.sector_rise)
	);

	// decode
	wire in_write = (state_r == sector_write_pkg::ST_WRITE);
	wire dclk = ev.write_clock_rise & in_write;
	wire upper_byte_phase = bit_ring_counter[3];
	wire wc_sync = (word_counter == sector_write_pkg::WC_SYNC);
	wire wc_addr = (word_counter == sector_write_pkg::WC_ADDR);
	wire wc_last = (word_counter == sector_write_pkg::WC_LAST);
	wire br_last = (bit_ring_counter == sector_write_pkg::BR_LAST);
	wire buffers_equal = (load_buffer_select == dump_buffer_select); // RQ5
	wire buffers_empty = buffers_equal & ~buffer_full_indicator; // RQ5
	wire address_transfer_mode = sector_flag; // RQ9
	wire address_strobe = transfer_stage_one & ~transfer_stage_two
		& ~exchange_command_present & ~channel_active_flag; // RQ8
	wire sr_path = data_phase_flag | wc_addr;
	wire shift_register_bus = upper_byte_phase ? shift_register_two[7]
		: shift_register_one[7]; // RQ15
	wire check_char_msb = check_char_shift_reg[7];
	wire ccr_drive = (wc_sync & upper_byte_phase)
		| (frame_active_flag & ~address_phase_flag); // RQ11
	wire wd_nxt = sr_path ? shift_register_bus
		: (ccr_drive ? check_char_msb : 1'b0); // RQ13
	wire frame_start = sector_flag & ~frame_active_flag & ~written_r;
	wire wrap_seek = track_wrap_memory
		& ~file_address_counter[sector_write_pkg::HEAD_BIT];
	wire slip = wrap_seek | (buffers_empty & ~terminate_received
		& ~frame_active_flag & increment_pulse_flag); // RQ24
	wire wr_en = psel & penable & pwrite;
	// ctrl: b0 start, b1 terminate, b2 first sector
	wire a_ctrl = (paddr == sector_write_pkg::A_CTRL);
	wire a_file_addr = (paddr == sector_write_pkg::A_FILE_ADDR);
	wire a_stat = (paddr == sector_write_pkg::A_STAT);
	wire [31:0] rd_mux = a_ctrl ? {29'h0, first_sector_flag,
		terminate_received, 1'b0}
		: a_file_addr ? {18'h0, file_address_counter}
		: a_stat ? {19'h0, word_counter, bit_ring_counter, state_r}
		: 32'h0;

	// apb: zero wait states, unmapped address errors
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~(a_ctrl | a_file_addr | a_stat);
			prdata  <= rd_mux;
		end
	end

	// sequence state and gates
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r             <= sector_write_pkg::ST_IDLE;
			write_gate_flag     <= 1'b0;
			read_gate_flag      <= 1'b1;
			cylinder_match_flag <= 1'b0;
			sector_flag         <= 1'b0;
			blank_count_flag    <= 1'b0;
			written_r           <= 1'b0;
		end
		else
		begin
			if (wr_en & a_ctrl & pwdata[0])
			begin
				state_r   <= sector_write_pkg::ST_WAIT;
				written_r <= 1'b0;
			end
			else if (state_r == sector_write_pkg::ST_WAIT && ev.sector_rise)
			begin
				state_r             <= sector_write_pkg::ST_WRITE;
				read_gate_flag      <= 1'b0; // RQ1
				write_gate_flag     <= 1'b1; // RQ1
				cylinder_match_flag <= 1'b0; // RQ1
				sector_flag         <= 1'b1;
				blank_count_flag    <= 1'b1;
			end
			else if (in_write)
			begin
				if (slip)
					state_r <= sector_write_pkg::ST_SLIP; // RQ24
				if (dclk & wc_sync)
					sector_flag <= 1'b0; // RQ10
				else if (ev.sector_rise)
					sector_flag <= 1'b1; // RQ20 re-armed for end check
				if (frame_start)
					written_r <= 1'b1;
				if (ev.sector_rise & written_r & ~frame_active_flag)
				begin
					write_gate_flag  <= 1'b0; // RQ25
					blank_count_flag <= 1'b0; // RQ25
				end
				if (wc_last & ~frame_active_flag & ~sector_flag)
					cylinder_match_flag <= 1'b1; // RQ23
			end
		end
	end

	// framing counters and phase flags, advanced on drive clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_counter       <= 7'h00;
			bit_ring_counter   <= 4'h0;
			frame_active_flag  <= 1'b0;
			address_phase_flag <= 1'b0;
			data_phase_flag    <= 1'b0;
			write_data_out     <= 1'b0;
		end
		else if (frame_start)
		begin
			word_counter       <= sector_write_pkg::WORDS_PER_SECTOR; // RQ3
			bit_ring_counter   <= 4'h0;
			address_phase_flag <= 1'b1; // RQ4
			frame_active_flag  <= 1'b1; // RQ4
		end
		else if (dclk & frame_active_flag)
		begin
			bit_ring_counter <= bit_ring_counter + 4'h1;
			write_data_out   <= wd_nxt;
			if (br_last & ~wc_last)
				word_counter <= word_counter - 7'h01; // RQ6
			if (br_last & wc_addr)
				data_phase_flag <= 1'b1; // RQ12
			if (br_last & wc_last)
			begin
				data_phase_flag    <= 1'b0; // RQ16
				address_phase_flag <= 1'b0; // RQ16
			end
			if (~address_phase_flag
				&& bit_ring_counter == sector_write_pkg::BR_CHECK_END)
				frame_active_flag <= 1'b0; // RQ17
		end
	end

	// check character and shifters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			check_char_shift_reg <= 8'h00;
			shift_register_one   <= 8'h00;
			shift_register_two   <= 8'h00;
		end
		else if (address_strobe & address_transfer_mode)
		begin
			// cylinder high bits, then low cylinder, head, sector
			shift_register_one <= file_address_counter[13:6]; // RQ9
			shift_register_two <= {file_address_counter[7:5],
				file_address_counter[4:0]}; // RQ9
		end
		else if (dclk & frame_active_flag)
		begin
			if (wc_sync && bit_ring_counter == sector_write_pkg::BR_SYNC_LOAD)
				check_char_shift_reg <= sector_write_pkg::SYNC_PATTERN; // RQ7
			else if (data_phase_flag)
				check_char_shift_reg <= {check_char_shift_reg[6:0],
					shift_register_bus ^ check_char_msb}; // RQ14
			else if (ccr_drive)
				check_char_shift_reg <= {check_char_shift_reg[6:0],
					1'b0}; // RQ7
			if (sr_path && bit_ring_counter == sector_write_pkg::BR_SR1_LOAD)
				shift_register_one <= output_latch[15:8]; // RQ21
			else if (sr_path & ~upper_byte_phase)
				shift_register_one <= {shift_register_one[6:0], 1'b0}; // RQ15
			if (data_phase_flag
				&& bit_ring_counter == sector_write_pkg::BR_SR2_LOAD)
				shift_register_two <= output_latch[7:0]; // RQ21
			else if (sr_path & upper_byte_phase)
				shift_register_two <= {shift_register_two[6:0], 1'b0}; // RQ15
		end
	end

	// buffer latch and shift strobe
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			output_latch        <= 16'h0000;
			buffer_shift_strobe <= 1'b0;
		end
		else
		begin
			if (dump_buffer_select & mos_clock_phase_three)
				output_latch <= mos_buffer_output; // RQ22
			buffer_shift_strobe <= dclk & data_phase_flag & dump_buffer_select
				& (bit_ring_counter == sector_write_pkg::BR_BUF_SHIFT); // RQ22
		end
	end

	// address, transfer handshake and end-of-sector flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			file_address_counter   <= sector_write_pkg::FILE_ADDR_RESET;
			frame_was_r            <= 1'b0;
			first_sector_flag      <= 1'b0;
			address_advance_flag   <= 1'b0;
			increment_pulse_flag   <= 1'b0;
			terminate_received     <= 1'b0;
			terminate_drained_flag <= 1'b0;
			transfer_stage_one     <= 1'b0;
			transfer_stage_two     <= 1'b0;
			track_wrap_memory      <= 1'b0;
			operation_end_flag     <= 1'b0;
		end
		else
		begin
			// frame end seen once, so the address advances once per sector
			frame_was_r <= frame_active_flag;
			if (wr_en & a_file_addr)
				file_address_counter <= pwdata[13:0];
			else if (address_advance_flag & ~first_sector_flag)
				file_address_counter <= file_address_counter + 14'h1; // RQ2
			if (wr_en & a_ctrl)
			begin
				terminate_received <= pwdata[1];
				first_sector_flag  <= pwdata[2];
			end
			else if (in_write & wc_addr)
				first_sector_flag <= 1'b0; // RQ18
			address_advance_flag <= in_write & ~address_advance_flag
				& ((wc_last & frame_was_r & ~frame_active_flag
				& ~first_sector_flag) | slip); // RQ19
			increment_pulse_flag <= address_advance_flag
				& ~increment_pulse_flag; // RQ19
			if (buffers_empty & terminate_received & data_phase_flag)
				terminate_drained_flag <= 1'b1; // RQ5
			if (address_transfer_mode & ~transfer_stage_two)
				transfer_stage_one <= 1'b1; // RQ8
			if (transfer_stage_two)
				transfer_stage_one <= 1'b0; // RQ8
			if (address_strobe)
				transfer_stage_two <= 1'b1; // RQ8
			else if (~address_transfer_mode)
				transfer_stage_two <= 1'b0; // RQ8
			if (in_write & file_address_counter[sector_write_pkg::HEAD_BIT])
				track_wrap_memory <= 1'b1; // RQ23
			if (sector_flag & terminate_drained_flag & ~frame_active_flag)
				operation_end_flag <= 1'b1; // RQ20
		end
	end

	// checks
	property p_wc_load;
		@(posedge pclk) disable iff (!presetn)
		frame_start |=> word_counter == sector_write_pkg::WORDS_PER_SECTOR
		&& frame_active_flag;
	endproperty
	a_wc_load: assert property (p_wc_load) else $error("word load"); // RQ3

	property p_dec;
		@(posedge pclk) disable iff (!presetn)
		dclk && frame_active_flag && br_last && !wc_last && !frame_start
		|=> word_counter == $past(word_counter) - 7'h01;
	endproperty
	a_dec: assert property (p_dec) else $error("word decrement"); // RQ6

	property p_file_addr_inc;
		@(posedge pclk) disable iff (!presetn)
		address_advance_flag && !first_sector_flag && !(wr_en && a_file_addr)
		|=> file_address_counter == $past(file_address_counter) + 14'h1;
	endproperty
	a_file_addr_inc: assert property (p_file_addr_inc)
		else $error("address advance"); // RQ2

	property p_inc;
		@(posedge pclk) disable iff (!presetn)
		increment_pulse_flag |=> !increment_pulse_flag;
	endproperty
	a_inc: assert property (p_inc) else $error("increment length"); // RQ19

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		state_r == sector_write_pkg::ST_WAIT && ev.sector_rise
		&& !(wr_en && a_ctrl && pwdata[0])
		|=> write_gate_flag && !read_gate_flag;
	endproperty
	a_start: assert property (p_start) else $error("gates"); // RQ1

	property p_data;
		@(posedge pclk) disable iff (!presetn)
		dclk && frame_active_flag && wc_addr && br_last && !frame_start
		|=> data_phase_flag;
	endproperty
	a_data: assert property (p_data) else $error("data phase"); // RQ12

	property p_end;
		@(posedge pclk) disable iff (!presetn)
		sector_flag && terminate_drained_flag && !frame_active_flag
		|=> operation_end_flag;
	endproperty
	a_end: assert property (p_end) else $error("operation end"); // RQ20

	property p_strobe;
		@(posedge pclk) disable iff (!presetn)
		address_strobe |-> !exchange_command_present && !channel_active_flag
		##1 transfer_stage_two;
	endproperty
	a_strobe: assert property (p_strobe) else $error("transfer"); // RQ8
endmodule
`default_nettype wire

// [testbench/drive_model.sv]
// behavioural disk drive: sector pulses on request, gated write clock,
// and capture of each written bit on the falling write clock edge
// assumes the controller raises its write gate for the whole frame
`default_nettype none
module drive_model
(
	// from controller
	input  wire logic write_gate_flag,
	input  wire logic write_data_out,
	// from bench
	input  wire logic sector_req,
	// to controller and bench
	output logic      write_clock_in,
	output logic      sector_pulse_in,
	output logic      bit_seen,
	output logic      bit_val
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		write_clock_in = 1'b0;
		sector_pulse_in = 1'b0;
		bit_seen = 1'b0;
		bit_val = 1'b0;
	end

	// one sector pulse per request, well wider than a sync stage
	always @(posedge sector_req)
	begin
		sector_pulse_in = 1'b1;
		#200;
		sector_pulse_in = 1'b0;
	end

	// 80 ns write clock, only while the gate is up; odd offset keeps phase loose
	initial
	begin
		#13;
		forever
		begin
			wait (write_gate_flag === 1'b1);
			#400;
			while (write_gate_flag === 1'b1)
			begin
				write_clock_in = 1'b1;
				#40;
				write_clock_in = 1'b0;
				bit_val = write_data_out;
				bit_seen = 1'b1;
				#10;
				bit_seen = 1'b0;
				#30;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_disk_sector_write_sequencer.sv]
// bench: one sector written with terminate pending, stream and regs checked
// assumes the drive model and the design package are compiled first
`default_nettype none
module tb_disk_sector_write_sequencer;
	timeunit 1ns;
	timeprecision 100ps;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        write_clock_in;
	logic        sector_pulse_in;
	logic        write_data_out;
	logic        write_gate_flag;
	logic        read_gate_flag;
	logic [15:0] mos_buffer_output = 16'h0000;
	logic        mos_clock_phase_three = 1'b0;
	logic        buffer_shift_strobe;
	logic        operation_end_flag;
	logic        sector_req = 1'b0;
	logic        bit_seen;
	logic        bit_val;
	logic        kick = 1'b0;
	logic        fetch = 1'b0;
	logic        synced = 1'b0;
	logic [7:0]  win = 8'h00;
	logic [7:0]  check_exp;
	logic [13:0] file_addr;
	logic [31:0] seed;
	logic [15:0] words [0:90];
	int          widx = 0;
	int          fails = 0;
	int          n_tests = 0;
	int          i;
	int          k;
	logic        bit_q [$];
	logic [32:0] exp_q [$];
	logic [32:0] mask_q [$];

	always #2 pclk = ~pclk;

	disk_sector_write_sequencer uut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.write_clock_in(write_clock_in), .sector_pulse_in(sector_pulse_in),
		.write_data_out(write_data_out), .write_gate_flag(write_gate_flag),
		.read_gate_flag(read_gate_flag),
		.mos_buffer_output(mos_buffer_output),
		.mos_clock_phase_three(mos_clock_phase_three),
		.load_buffer_select(1'b1), .dump_buffer_select(1'b1),
		.buffer_full_indicator(1'b0), .exchange_command_present(1'b0),
		.channel_active_flag(1'b0),
		.buffer_shift_strobe(buffer_shift_strobe),
		.operation_end_flag(operation_end_flag)
	);

	drive_model drive
	(
		.write_gate_flag(write_gate_flag), .write_data_out(write_data_out),
		.sector_req(sector_req), .write_clock_in(write_clock_in),
		.sector_pulse_in(sector_pulse_in), .bit_seen(bit_seen),
		.bit_val(bit_val)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	task automatic cmp_bit(input logic got, input logic exp, input string w);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s got %b", $time, w, got);
		end
	endtask

	task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp,
		input logic [32:0] m);
		n_tests++;
		if ((got & m) !== (exp & m))
		begin
			fails++;
			$display("unexpected at %0t: read got %h", $time, got);
		end
	endtask

	// setup, then access held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait limit here: only the watchdog ends a hung access
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic apb_read(input logic [11:0] a, input logic [32:0] e,
		input logic [32:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic push_byte(input logic [7:0] b);
		for (int j = 7; j >= 0; j--)
			bit_q.push_back(b[j]);
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// read data watcher: oldest expectation against each read answer
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			if (exp_q.size() == 0)
				cmp_word({pslverr, prdata}, 33'h0, 33'h0_0000_0000);
			else
				cmp_word({pslverr, prdata}, exp_q.pop_front(),
					mask_q.pop_front());
		end
	end

	// stream watcher: hunt for the sync byte, then match the frame bit by bit
	always @(posedge bit_seen)
	begin
		if (!synced)
		begin
			win = {win[6:0], bit_val};
			synced = (win === sector_write_pkg::SYNC_PATTERN);
		end
		else if (bit_q.size() > 0)
			cmp_bit(bit_val, bit_q.pop_front(), "write data");
	end

	// buffer storage: next word and a latch strobe after each shift request
	always @(posedge pclk)
	begin
		mos_clock_phase_three <= fetch;
		fetch <= (buffer_shift_strobe === 1'b1) || kick;
		if (((buffer_shift_strobe === 1'b1) || kick) && widx < 91)
		begin
			mos_buffer_output <= words[widx];
			widx <= widx + 1;
		end
	end

	// hang guard, about twice one sector's length
	initial
	begin
		#300000;
		fails++;
		complete_run;
	end

	initial
	begin
		seed = 32'hF28FFB4A;
		check_exp = 8'h00;
		for (k = 0; k < 91; k++)
		begin
			seed = lfsr(seed);
			words[k] = seed[15:0];
		end
		seed = lfsr(seed);
		file_addr = seed[13:0];
		file_addr[sector_write_pkg::HEAD_BIT] = 1'b0; // no track wrap slip
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp_bit(read_gate_flag, 1'b1, "read gate at reset");
		cmp_bit(write_gate_flag, 1'b0, "write gate at reset");
		cmp_bit(operation_end_flag, 1'b0, "end flag at reset");
		apb_read(12'hFFC, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		apb(1'b1, sector_write_pkg::A_FILE_ADDR, {18'h0, file_addr});
		apb_read(sector_write_pkg::A_FILE_ADDR, {19'h0, file_addr},
			33'h0_0000_3FFF);
		$display("test registers done");
		// expected frame after sync: address, 180 data bytes, check byte
		push_byte(file_addr[13:6]);
		push_byte(file_addr[7:0]);
		for (k = 0; k < 90; k++)
		begin
			push_byte(words[k][15:8]);
			push_byte(words[k][7:0]);
			check_exp = check_exp ^ words[k][15:8] ^ words[k][7:0];
		end
		push_byte(check_exp);
		kick <= 1'b1;
		@(posedge pclk);
		kick <= 1'b0;
		apb(1'b1, sector_write_pkg::A_CTRL, 32'h00000001);
		sector_req <= 1'b1;
		@(posedge pclk);
		sector_req <= 1'b0;
		for (i = 0; i < 300 && write_gate_flag !== 1'b1; i++)
			@(posedge pclk);
		cmp_bit(write_gate_flag, 1'b1, "write gate");
		cmp_bit(read_gate_flag, 1'b0, "read gate");
		apb_read(sector_write_pkg::A_STAT, 33'h0_0000_1B00,
			33'h0_0000_1FFC);
		apb(1'b1, sector_write_pkg::A_CTRL, 32'h00000002);
		apb_read(sector_write_pkg::A_CTRL, 33'h0_0000_0002,
			33'h0_0000_0002);
		for (i = 0; i < 60000 && bit_q.size() > 0; i++)
			@(posedge pclk);
		cmp_bit(synced, 1'b1, "sync found");
		cmp_bit(bit_q.size() == 0, 1'b1, "frame complete");
		repeat (400) @(posedge pclk);
		apb_read(sector_write_pkg::A_FILE_ADDR, {19'h0, file_addr + 14'h0001},
			33'h0_0000_3FFF);
		$display("test sector stream done");
		sector_req <= 1'b1;
		@(posedge pclk);
		sector_req <= 1'b0;
		for (i = 0; i < 300 && operation_end_flag !== 1'b1; i++)
			@(posedge pclk);
		cmp_bit(operation_end_flag, 1'b1, "operation end");
		cmp_bit(write_gate_flag, 1'b0, "write gate drop");
		$display("test terminate done");
		repeat (4) @(posedge pclk);
		cmp_bit(exp_q.size() == 0, 1'b1, "reads answered");
		complete_run;
	end
endmodule
`default_nettype wire
